//--- core/mcod_pkg.sv
package mcod_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int JUMP_W = 10;
    localparam int NUM_GPR = 5;

    // ------------------------------------------------------------
    // instruction layout
    // ------------------------------------------------------------
    localparam logic [5:0] OPC_ADD = 6'h0A;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 10;
    localparam int RES_HI = 9;
    localparam int RES_LO = 7;
    localparam int ZERO_BIT = 6;
    localparam int SRC2_HI = 5;
    localparam int SRC2_LO = 3;
    localparam int SRC1_HI = 2;
    localparam int SRC1_LO = 0;

    // ------------------------------------------------------------
    // arithmetic operand set codes
    // ------------------------------------------------------------
    localparam logic [2:0] ALU_R4 = 3'h4;
    localparam logic [2:0] ALU_IMM = 3'h5;
    localparam logic [2:0] ALU_MH = 3'h6;
    localparam logic [2:0] ALU_ML = 3'h7;

    // ------------------------------------------------------------
    // full core operand set codes
    // ------------------------------------------------------------
    localparam logic [4:0] FC_ARITH = 5'h08;
    localparam logic [4:0] FC_AUX = 5'h09;
    localparam logic [4:0] FC_JMPA = 5'h0A;
    localparam logic [4:0] FC_JMPB = 5'h0B;
    localparam logic [4:0] FC_CNT_A = 5'h0C;
    localparam logic [4:0] FC_EOC_A = 5'h10;
    localparam logic [4:0] FC_FLAG = 5'h14;
    localparam logic [4:0] FC_CTRL = 5'h15;
    localparam logic [4:0] FC_STAT = 5'h16;
    localparam logic [4:0] FC_SDATA = 5'h17;
    localparam logic [4:0] FC_THR_A = 5'h18;
    localparam logic [4:0] FC_THR_E = 5'h1C;
    localparam logic [4:0] FC_SADDR = 5'h1D;
    localparam logic [4:0] FC_IRQ = 5'h1E;
    localparam logic [4:0] FC_XCH = 5'h1F;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] REG_RST = 16'h0000;
    localparam logic [9:0] JUMP_RST = 10'h000;

    // ------------------------------------------------------------
    // decoded target classes of the full core operand set
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        MCOD_T_ALU = 4'h0,
        MCOD_T_ARITH = 4'h1,
        MCOD_T_AUX = 4'h2,
        MCOD_T_JUMP = 4'h3,
        MCOD_T_CNT = 4'h4,
        MCOD_T_EOC = 4'h5,
        MCOD_T_FLAG = 4'h6,
        MCOD_T_CTRL = 4'h7,
        MCOD_T_STAT = 4'h8,
        MCOD_T_SDATA = 4'h9,
        MCOD_T_THR = 4'hA,
        MCOD_T_SADDR = 4'hB,
        MCOD_T_IRQ = 4'hC,
        MCOD_T_XCH = 4'hD
    } mcod_target_t;

    // full core decode answer
    typedef struct packed {
        mcod_target_t target;
        logic [2:0] index;
    } mcod_sel_t;

    // condition flags written by the addition
    typedef struct packed {
        logic carry;
        logic zero;
        logic sign;
        logic uUnder;
        logic uOver;
        logic sUnder;
        logic sOver;
    } mcod_flags_t;

    // execution states, one-hot
    typedef enum logic [1:0] {
        MCOD_IDLE = 2'b01,
        MCOD_DONE = 2'b10
    } mcod_state_t;

endpackage

//--- core/mcod_full_decode.sv
`timescale 1ns/10ps
// maps a 5-bit full core operand code onto a register class and index
module mcod_full_decode
    import mcod_pkg::*;
(
    input wire logic [4:0] code,
    output mcod_sel_t sel
);

    // ------------------------------------------------------------
    // fixed decode table
    // ------------------------------------------------------------
    always_comb
    begin
        sel.index = code[2:0];
        sel.target = MCOD_T_ALU;
        if (code < FC_ARITH)
        begin
            sel.target = MCOD_T_ALU;
        end
        else if (code == FC_ARITH)
        begin
            sel.target = MCOD_T_ARITH;
        end
        else if (code == FC_AUX)
        begin
            sel.target = MCOD_T_AUX;
        end
        else if (code == FC_JMPA || code == FC_JMPB)
        begin
            sel.target = MCOD_T_JUMP;
            sel.index = {2'b00, code[0]};
        end
        else if (code < FC_EOC_A)
        begin
            sel.target = MCOD_T_CNT;
            sel.index = {1'b0, code[1:0]};
        end
        else if (code < FC_FLAG)
        begin
            sel.target = MCOD_T_EOC;
            sel.index = {1'b0, code[1:0]};
        end
        else if (code == FC_FLAG)
        begin
            sel.target = MCOD_T_FLAG;
        end
        else if (code == FC_CTRL)
        begin
            sel.target = MCOD_T_CTRL;
        end
        else if (code == FC_STAT)
        begin
            sel.target = MCOD_T_STAT;
        end
        else if (code == FC_SDATA)
        begin
            sel.target = MCOD_T_SDATA;
        end
        else if (code <= FC_THR_E)
        begin
            sel.target = MCOD_T_THR;
            sel.index = 3'(code - FC_THR_A);
        end
        else if (code == FC_SADDR)
        begin
            sel.target = MCOD_T_SADDR;
        end
        else if (code == FC_IRQ)
        begin
            sel.target = MCOD_T_IRQ;
        end
        else
        begin
            sel.target = MCOD_T_XCH;
        end
    end

endmodule

//--- core/mcod_core.sv
`timescale 1ns/10ps
module mcod_core
    import mcod_pkg::*;
#(
    parameter int DW = DATA_W,
    parameter int JW = JUMP_W
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEn,
    // instruction issue
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    // immediate and product halves loaded by other units
    input wire logic immLoad,
    input wire logic [DW-1:0] immData,
    input wire logic productLoad,
    input wire logic [2*DW-1:0] productData,
    // jump register loads and far jump requests
    input wire logic jumpLoad,
    input wire logic jumpLoadSel,
    input wire logic [JW-1:0] jumpLoadAddr,
    input wire logic farJump,
    input wire logic farJumpSel,
    // operand decode requests
    input wire logic [4:0] fullCode,
    input wire logic [2:0] genImmCode,
    // results
    output logic addDone,
    output logic badInstr,
    output logic [DW-1:0] gprOut [NUM_GPR],
    output logic [DW-1:0] immOut,
    output logic [DW-1:0] prodHighOut,
    output logic [DW-1:0] prodLowOut,
    output mcod_flags_t flagsOut,
    output logic [JW-1:0] jumpAOut,
    output logic [JW-1:0] jumpBOut,
    output logic [JW-1:0] progCounter,
    output logic pcLoaded,
    output mcod_sel_t fullSel,
    output logic [2:0] genImmSel,
    output logic genImmBad
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        mcod_state_t state;
        logic [NUM_GPR-1:0][DW-1:0] gpr;
        logic [DW-1:0] imm;
        logic [DW-1:0] prodHi;
        logic [DW-1:0] prodLo;
        mcod_flags_t flags;
        logic [JW-1:0] jumpA;
        logic [JW-1:0] jumpB;
        logic [JW-1:0] pc;
        logic pcLoaded;
        logic addDone;
        logic badInstr;
        mcod_sel_t fullSel;
        logic [2:0] genImmSel;
        logic genImmBad;
    } mcod_core_t;

    // reset image of the whole state, loaded in one go
    localparam mcod_core_t STATE_RST = '{
        state: MCOD_IDLE,
        gpr: '0,
        imm: DW'(REG_RST),
        prodHi: '0,
        prodLo: '0,
        flags: '0,
        jumpA: JW'(JUMP_RST),
        jumpB: JW'(JUMP_RST),
        pc: '0,
        pcLoaded: 1'b0,
        addDone: 1'b0,
        badInstr: 1'b0,
        fullSel: '0,
        genImmSel: 3'h0,
        genImmBad: 1'b0
    };

    mcod_core_t state_r;
    mcod_core_t state_nxt;
    mcod_sel_t fullDec;
    logic isAdd;
    logic [2:0] srcA;
    logic [2:0] srcB;
    logic [2:0] dest;
    logic [DW-1:0] opA;
    logic [DW-1:0] opB;
    logic [DW:0] sumWide;
    logic [DW-1:0] sum;
    logic sgnOvf;
    mcod_flags_t addFlags;
    logic [JW-1:0] farTarget;

    // reads an arithmetic set register from a given state
    function automatic logic [DW-1:0] aluRead(input mcod_core_t s, input logic [2:0] code);
        logic [DW-1:0] v;
        v = s.prodLo;
        if (code <= ALU_R4)
        begin
            v = s.gpr[code];
        end
        else if (code == ALU_IMM)
        begin
            v = s.imm;
        end
        else if (code == ALU_MH)
        begin
            v = s.prodHi;
        end
        else
        begin
            v = s.prodLo;
        end
        return v;
    endfunction

    // writes a value into an arithmetic set register of a given state
    function automatic mcod_core_t aluWrite(input mcod_core_t s, input logic [2:0] code,
        input logic [DW-1:0] val);
        mcod_core_t t;
        t = s;
        if (code <= ALU_R4)
        begin
            t.gpr[code] = val;
        end
        else if (code == ALU_IMM)
        begin
            t.imm = val;
        end
        else if (code == ALU_MH)
        begin
            t.prodHi = val;
        end
        else
        begin
            t.prodLo = val;
        end
        return t;
    endfunction

    // ------------------------------------------------------------
    // full core operand decoder
    // ------------------------------------------------------------
    mcod_full_decode uFullDec
    (
        .code(fullCode),
        .sel(fullDec)
    );

    // ------------------------------------------------------------
    // instruction field split and adder
    // ------------------------------------------------------------
    assign isAdd = instrWord[OPC_HI:OPC_LO] == OPC_ADD && !instrWord[ZERO_BIT];
    assign dest = instrWord[RES_HI:RES_LO];
    assign srcB = instrWord[SRC2_HI:SRC2_LO];
    assign srcA = instrWord[SRC1_HI:SRC1_LO];
    assign opA = aluRead(state_r, srcA);
    assign opB = aluRead(state_r, srcB);
    assign sumWide = {1'b0, opA} + {1'b0, opB};
    assign sum = sumWide[DW-1:0];
    assign sgnOvf = (opA[DW-1] == opB[DW-1]) && (sum[DW-1] != opA[DW-1]);
    // far jump target picked by the 1-bit jump operand
    assign farTarget = farJumpSel ? state_r.jumpB : state_r.jumpA;

    // ------------------------------------------------------------
    // condition flags of the addition
    // ------------------------------------------------------------
    always_comb
    begin
        addFlags.carry = sumWide[DW];
        addFlags.zero = sum == '0;
        addFlags.sign = sum[DW-1];
        addFlags.uUnder = 1'b0;
        addFlags.uOver = sumWide[DW];
        addFlags.sUnder = sgnOvf && opA[DW-1];
        addFlags.sOver = sgnOvf && !opA[DW-1];
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.addDone = 1'b0;
        state_nxt.badInstr = 1'b0;
        state_nxt.pcLoaded = 1'b0;
        // external loads of immediate and product halves
        if (immLoad)
        begin
            state_nxt.imm = immData;
        end
        if (productLoad)
        begin
            state_nxt.prodHi = productData[2*DW-1:DW];
            state_nxt.prodLo = productData[DW-1:0];
        end
        // jump registers keep 10-bit absolute addresses
        if (jumpLoad && !jumpLoadSel)
        begin
            state_nxt.jumpA = jumpLoadAddr;
        end
        if (jumpLoad && jumpLoadSel)
        begin
            state_nxt.jumpB = jumpLoadAddr;
        end
        // far jump copies the selected jump register, which is left intact
        if (farJump)
        begin
            state_nxt.pc = farTarget;
            state_nxt.pcLoaded = 1'b1;
        end
        // registered decode answers for the other operand sets
        state_nxt.fullSel = fullDec;
        state_nxt.genImmSel = genImmCode;
        state_nxt.genImmBad = genImmCode > ALU_IMM;
        // addition execution
        case (state_r.state)
            MCOD_IDLE:
            begin
                if (instrValid && isAdd)
                begin
                    state_nxt = aluWrite(state_nxt, dest, sum);
                    state_nxt.flags = addFlags;
                    state_nxt.addDone = 1'b1;
                    state_nxt.state = MCOD_DONE;
                end
                else if (instrValid)
                begin
                    state_nxt.badInstr = 1'b1;
                end
            end
            MCOD_DONE:
            begin
                state_nxt.state = MCOD_IDLE;
            end
            default:
            begin
                state_nxt.state = MCOD_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // register stage
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            state_r <= STATE_RST;
        end
        else if (clkEn)
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from the state
    // ------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < NUM_GPR; i++)
        begin
            gprOut[i] = state_r.gpr[i];
        end
    end
    // register contents
    assign immOut = state_r.imm;
    assign prodHighOut = state_r.prodHi;
    assign prodLowOut = state_r.prodLo;
    assign flagsOut = state_r.flags;
    assign jumpAOut = state_r.jumpA;
    assign jumpBOut = state_r.jumpB;
    assign progCounter = state_r.pc;
    // pulses and decode answers
    assign pcLoaded = state_r.pcLoaded;
    assign addDone = state_r.addDone;
    assign badInstr = state_r.badInstr;
    assign fullSel = state_r.fullSel;
    assign genImmSel = state_r.genImmSel;
    assign genImmBad = state_r.genImmBad;

endmodule

//--- test/mcod_core_asserts.sv
`timescale 1ns/10ps
// watches the decode and addition timing at the core ports
module mcod_core_asserts
    import mcod_pkg::*;
#(
    parameter int JW = JUMP_W
)
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic instrValid,
    input wire logic [15:0] instrWord,
    input wire logic jumpLoad,
    input wire logic farJump,
    input wire logic farJumpSel,
    input wire logic [4:0] fullCode,
    input wire logic [2:0] genImmCode,
    input wire logic addDone,
    input wire logic badInstr,
    input wire logic [JW-1:0] jumpAOut,
    input wire logic [JW-1:0] jumpBOut,
    input wire logic [JW-1:0] progCounter,
    input wire logic pcLoaded,
    input mcod_sel_t fullSel,
    input wire logic [2:0] genImmSel,
    input wire logic genImmBad
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_ADD_DONE: assert property (clkEn && instrValid && !addDone &&
        instrWord[15:10] == OPC_ADD && !instrWord[6] |=> addDone) else $error("add lost");
    AST_ADD_GAP: assert property (clkEn && addDone |=> !addDone && !badInstr)
        else $error("instruction taken after add");
    AST_BAD_WORD: assert property (clkEn && instrValid && !addDone &&
        instrWord[15:10] != OPC_ADD |=> badInstr && !addDone) else $error("bad word missed");
    AST_GI_BAD: assert property (clkEn |=> genImmBad == ($past(genImmCode) > 3'h5))
        else $error("general imm refusal wrong");
    AST_GI_SEL: assert property (clkEn |=> genImmSel == $past(genImmCode))
        else $error("general imm select wrong");
    AST_PC_A: assert property (clkEn && farJump && !farJumpSel && !jumpLoad
        |=> pcLoaded && progCounter == $past(jumpAOut)) else $error("jump a wrong");
    AST_PC_B: assert property (clkEn && farJump && farJumpSel && !jumpLoad
        |=> pcLoaded && progCounter == $past(jumpBOut)) else $error("jump b wrong");
    AST_JUMP_KEEP: assert property (clkEn && farJump && !jumpLoad
        |=> $stable(jumpAOut) && $stable(jumpBOut)) else $error("jump register changed");
    AST_FULL_ALU: assert property (clkEn && fullCode[4:3] == 2'b00 |=>
        fullSel.target == MCOD_T_ALU && fullSel.index == $past(fullCode[2:0]))
        else $error("full alu decode wrong");
endmodule

//--- test/mcod_core_bench.sv
`timescale 1ns/10ps
module mcod_core_bench
    import mcod_pkg::*;
;
    logic mclk, rst_n, clkEn, instrValid, immLoad, productLoad, jumpLoad, jumpLoadSel;
    logic farJump, farJumpSel, addDone, badInstr, pcLoaded, genImmBad;
    logic [15:0] instrWord, immData, immOut, prodHighOut, prodLowOut;
    logic [15:0] gprOut [NUM_GPR];
    logic [15:0] m [8];
    logic [31:0] productData;
    logic [9:0] jumpLoadAddr, jumpAOut, jumpBOut, progCounter;
    logic [4:0] fullCode;
    logic [2:0] genImmCode, genImmSel;
    mcod_flags_t flagsOut;
    mcod_sel_t fullSel;
    int n_mismatch, num_checks;

    mcod_core u_mcod_core (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
        .instrValid(instrValid), .instrWord(instrWord), .immLoad(immLoad),
        .immData(immData), .productLoad(productLoad), .productData(productData),
        .jumpLoad(jumpLoad), .jumpLoadSel(jumpLoadSel), .jumpLoadAddr(jumpLoadAddr),
        .farJump(farJump), .farJumpSel(farJumpSel), .fullCode(fullCode),
        .genImmCode(genImmCode), .addDone(addDone), .badInstr(badInstr), .gprOut(gprOut),
        .immOut(immOut), .prodHighOut(prodHighOut), .prodLowOut(prodLowOut),
        .flagsOut(flagsOut), .jumpAOut(jumpAOut), .jumpBOut(jumpBOut),
        .progCounter(progCounter), .pcLoaded(pcLoaded), .fullSel(fullSel),
        .genImmSel(genImmSel), .genImmBad(genImmBad));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task tick;
        @(posedge mclk);
        #1;
    endtask

    task chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %0t %s", $time, msg);
        end
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // arithmetic set register as seen at the ports
    function logic [15:0] alu_val(input logic [2:0] c);
        if (c < 3'h5)
            return gprOut[c];
        return (c == 3'h5) ? immOut : (c == 3'h6) ? prodHighOut : prodLowOut;
    endfunction

    // expected class and index of a full set code
    function mcod_sel_t exp_full(input logic [4:0] c);
        mcod_sel_t s;
        s = {MCOD_T_ALU, c[2:0]}; // single registers keep the low code bits as index
        if (c < 5'h08) s = {MCOD_T_ALU, c[2:0]};
        else if (c < 5'h0A) s.target = c[0] ? MCOD_T_AUX : MCOD_T_ARITH;
        else if (c < 5'h0C) s = {MCOD_T_JUMP, 2'b00, c[0]};
        else if (c < 5'h10) s = {MCOD_T_CNT, 1'b0, c[1:0]};
        else if (c < 5'h14) s = {MCOD_T_EOC, 1'b0, c[1:0]};
        else if (c < 5'h18) s.target = mcod_target_t'(4'h6 + {2'b00, c[1:0]});
        else if (c < 5'h1D) s = {MCOD_T_THR, c[2:0]};
        else s.target = mcod_target_t'(4'hA + {2'b00, c[1:0]});
        return s;
    endfunction

    // one add; hold keeps a second add up in the refused cycle
    task do_add(input logic [2:0] op1, input logic [2:0] op2, input logic [2:0] res,
        input logic hold);
        logic [16:0] s;
        mcod_flags_t f;
        s = {1'b0, m[op1]} + {1'b0, m[op2]};
        f = {s[16], s[15:0] == 16'h0000, s[15], 1'b0, s[16],
            m[op1][15] & m[op2][15] & ~s[15], ~m[op1][15] & ~m[op2][15] & s[15]};
        m[res] = s[15:0];
        instrWord = {OPC_ADD, res, 1'b0, op2, op1};
        instrValid = 1'b1;
        tick;
        instrValid = hold;
        instrWord = {OPC_ADD, 3'h3, 1'b0, 3'h5, 3'h5};
        chk(addDone, 1, "add done");
        chk(alu_val(res), m[res], "sum");
        chk(flagsOut, f, "flags");
        tick;
        chk(addDone, 0, "add pulse");
        chk(gprOut[3], m[3], "refused add");
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and tests
    // ------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // cuts a hang short
    initial
    begin
        #20000;
        n_mismatch++;
        end_sim;
    end

    // main sequence
    initial
    begin
        {rst_n, instrValid, immLoad, productLoad, jumpLoad, jumpLoadSel} = '0;
        {farJump, farJumpSel, instrWord, immData, productData} = '0;
        {jumpLoadAddr, fullCode, genImmCode} = '0;
        clkEn = 1'b1;
        n_mismatch = 0;
        num_checks = 0;
        m = '{default: 16'h0000};
        repeat (20) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        chk({addDone, flagsOut, progCounter, gprOut[0]}, 0, "reset values");
        immData = 16'h7FFF;
        productData = 32'h8000_0001;
        {immLoad, productLoad} = 2'b11;
        tick;
        {immLoad, productLoad} = 2'b00;
        chk({immOut, prodHighOut, prodLowOut}, {immData, productData}, "loads");
        m[5] = 16'h7FFF;
        m[6] = 16'h8000;
        m[7] = 16'h0001;
        clkEn = 1'b0;
        immData = 16'h1234;
        immLoad = 1'b1;
        tick;
        {clkEn, immLoad} = 2'b10;
        chk(immOut, 16'h7FFF, "frozen");
        $display("load test done");
        do_add(3'h5, 3'h7, 3'h0, 1'b1);
        do_add(3'h6, 3'h6, 3'h1, 1'b0);
        do_add(3'h0, 3'h5, 3'h4, 1'b0);
        do_add(3'h4, 3'h1, 3'h6, 1'b0);
        do_add(3'h4, 3'h7, 3'h7, 1'b0);
        $display("add test done");
        instrWord = 16'h2C00;
        instrValid = 1'b1;
        tick;
        instrValid = 1'b0;
        chk({badInstr, addDone}, 2'b10, "bad word");
        tick;
        chk(badInstr, 0, "bad pulse");
        for (int i = 0; i < 32; i++)
        begin
            fullCode = 5'(i);
            genImmCode = 3'(i);
            tick;
            chk(fullSel, exp_full(5'(i)), "full decode");
            chk({genImmBad, genImmSel}, {3'(i) > 3'h5, 3'(i)}, "gen imm");
        end
        $display("decode test done");
        {jumpLoad, jumpLoadSel, jumpLoadAddr} = {2'b10, 10'h3FF};
        tick;
        {jumpLoadSel, jumpLoadAddr} = {1'b1, 10'h155};
        tick;
        {jumpLoad, farJump, farJumpSel} = 3'b010;
        chk({jumpAOut, jumpBOut}, {10'h3FF, 10'h155}, "jump load");
        tick;
        farJumpSel = 1'b1;
        chk({pcLoaded, progCounter}, {1'b1, 10'h3FF}, "far jump a");
        tick;
        farJump = 1'b0;
        chk({pcLoaded, progCounter}, {1'b1, 10'h155}, "far jump b");
        tick;
        chk({pcLoaded, jumpAOut, jumpBOut}, {1'b0, 10'h3FF, 10'h155}, "jump kept");
        $display("jump test done");
        end_sim;
    end
endmodule

bind mcod_core mcod_core_asserts #(.JW(JW)) u_mcod_core_asserts (.mclk(mclk), .rst_n(rst_n),
    .clkEn(clkEn), .instrValid(instrValid), .instrWord(instrWord), .jumpLoad(jumpLoad),
    .farJump(farJump), .farJumpSel(farJumpSel), .fullCode(fullCode),
    .genImmCode(genImmCode), .addDone(addDone), .badInstr(badInstr), .jumpAOut(jumpAOut),
    .jumpBOut(jumpBOut), .progCounter(progCounter), .pcLoaded(pcLoaded), .fullSel(fullSel),
    .genImmSel(genImmSel), .genImmBad(genImmBad));
